/* verilog/adcms_regs.vh */
`ifndef ADCMS_REGS_VH
`define ADCMS_REGS_VH

// Register indices; the Wishbone byte address is four times the index.
`define ADCMS_IDX_STATUS 8'h01
`define ADCMS_IDX_GAIN 8'h03
`define ADCMS_IDX_DRATE 8'h04
`define ADCMS_IDX_REF 8'h05
`define ADCMS_IDX_EXC1 8'h06
`define ADCMS_IDX_EXC2 8'h07
`define ADCMS_IDX_CLKSEL 8'h0C

// Field positions.
`define ADCMS_STAT_RDYN 0
`define ADCMS_STAT_SUPUP 1
`define ADCMS_STAT_ST_LO 4
`define ADCMS_GAIN_AMP_HI 1
`define ADCMS_GAIN_AMP_LO 0
`define ADCMS_GAIN_DLY_HI 15
`define ADCMS_GAIN_DLY_LO 4
`define ADCMS_DRATE_MODE 0
`define ADCMS_DRATE_LOWLAT 1
`define ADCMS_REF_VREF_HI 1
`define ADCMS_REF_VREF_LO 0
`define ADCMS_REF_KEEP 2
`define ADCMS_CLK_EXT 0

// Reset values.
`define ADCMS_GAIN_RST 16'h00D1
`define ADCMS_DRATE_RST 2'h0
`define ADCMS_REF_RST 3'h1
`define ADCMS_EXC_RST 8'h00
`define ADCMS_CLK_RST 1'h0

// Command opcodes: the upper seven bits of the command byte.
`define ADCMS_OP_RESUME 7'h01
`define ADCMS_OP_SLEEP 7'h02
`define ADCMS_OP_RESET 7'h03
`define ADCMS_OP_START 7'h04
`define ADCMS_OP_STOP 7'h05
`define ADCMS_OP_CAL 7'h0C

// Pin vector: bit positions and idle levels.
`define ADCMS_PIN_SCLK 0
`define ADCMS_PIN_CS 1
`define ADCMS_PIN_DIN 2
`define ADCMS_PIN_TRIG 3
`define ADCMS_PIN_RST 4
`define ADCMS_PIN_IDLE 5'h12

// Timing.
`define ADCMS_TCLK_NS 20
`define ADCMS_POR_TIME_US 2200
`define ADCMS_STARTUP_CLKS (`ADCMS_POR_TIME_US * 1000 / `ADCMS_TCLK_NS)
`define ADCMS_RST_PIN_MIN_CLKS 3'h4
`define ADCMS_CMD_LAT_CLKS 2
`define ADCMS_TMOD_SHIFT 4
`define ADCMS_CONV_CLKS 16'h0400
`define ADCMS_SINC3_SKIP 2'h2

`endif

/* verilog/adcms_top.v */
`default_nettype none
`include "adcms_regs.vh"
// Contract
// - Any reset restores configuration defaults and enters standby.
// - After reset, stay in standby until trigger rising edge or START.
// - Any reset selects the internal oscillator again.
// - Power-on sequence completion sets supply_up_flag.
// - Ready bit at 01h goes to zero once start-up configuration ends.
// - Command byte 06h or 07h resets, decoded at seventh falling edge.
// - Power-down switches everything off, reference optional, registers kept.
// - Power-down starts 2 clocks after seventh edge of sleep_cmd.
// - Power-down runs reads, resume and status flag clear, ignores configuration writes and reset command.
// - resume_cmd in power-down enters standby, awaiting a start.
// - Standby whenever idle: after stop, trigger low, or single shot.
// - Standby holds the filter in reset and gates core clock.
// - Standby fields 00 power down amplifier, reference and current sources.
// - Calibration commands are not decoded in standby.
// - Mode bit selects continuous or single-shot; both need a start.
// - Continuous stop finishes current conversion, then standby.
// - Single-shot converts once per trigger, then standby.
// - Single-shot with sinc3 discards two results, outputs the third.
// - START, STOP and trigger rise act two clocks later.
// - Settle delay of 1 to 4096 periods of 16 clocks precedes conversion.
module adcms_top #(
    parameter [16:0] STARTUP_CLKS = `ADCMS_STARTUP_CLKS
) (
    input wire clk_i,
    input wire nrst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire spi_sclk_i,
    input wire spi_cs_n_i,
    input wire spi_din_i,
    input wire conv_trig_i,
    input wire rst_pin_n_i,
    output reg drdy_n_o,
    output reg result_valid_o,
    output reg cal_start_o,
    output reg filt_rst_o,
    output reg core_clk_en_o,
    output reg pwr_down_o,
    output reg amp_pwr_o,
    output reg vref_pwr_o,
    output reg idac_pwr_o,
    output reg clk_ext_sel_o,
    output reg [3:0] mode_state_o
);

    localparam [3:0] ST_PDN = 4'h1;
    localparam [3:0] ST_STBY = 4'h2;
    localparam [3:0] ST_DLY = 4'h4;
    localparam [3:0] ST_CONV = 4'h8;
    localparam LAT = `ADCMS_CMD_LAT_CLKS;

    reg [1:0] rsync_q;
    wire rst_n;

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end

    assign rst_n = rsync_q[1];

    // Pins pass three flops; a level counts once the last two agree.
    wire [4:0] pin_raw;
    reg [4:0] ps1_q;
    reg [4:0] ps2_q;
    reg [4:0] ps3_q;
    reg [4:0] pf_q;
    reg [4:0] pp_q;
    wire [4:0] pin_dis;
    wire [4:0] pf_d;

    assign pin_raw = {rst_pin_n_i, conv_trig_i, spi_din_i, spi_cs_n_i, spi_sclk_i};
    assign pin_dis = ps2_q ^ ps3_q;
    assign pf_d = (~pin_dis & ps3_q) | (pin_dis & pf_q);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ps1_q <= `ADCMS_PIN_IDLE;
            ps2_q <= `ADCMS_PIN_IDLE;
            ps3_q <= `ADCMS_PIN_IDLE;
            pf_q <= `ADCMS_PIN_IDLE;
            pp_q <= `ADCMS_PIN_IDLE;
        end else if (ce_i) begin
            ps1_q <= pin_raw;
            ps2_q <= ps1_q;
            ps3_q <= ps2_q;
            pf_q <= pf_d;
            pp_q <= pf_q;
        end
    end

    wire sclk_fall = pp_q[`ADCMS_PIN_SCLK] & ~pf_q[`ADCMS_PIN_SCLK];
    wire sclk_rise = ~pp_q[`ADCMS_PIN_SCLK] & pf_q[`ADCMS_PIN_SCLK];
    wire cs_act = ~pf_q[`ADCMS_PIN_CS];
    wire din = pf_q[`ADCMS_PIN_DIN];
    wire trig_rise = ~pp_q[`ADCMS_PIN_TRIG] & pf_q[`ADCMS_PIN_TRIG];
    wire trig_fall = pp_q[`ADCMS_PIN_TRIG] & ~pf_q[`ADCMS_PIN_TRIG];
    wire rstp_rise = ~pp_q[`ADCMS_PIN_RST] & pf_q[`ADCMS_PIN_RST];

    reg [3:0] state_q;
    wire in_pdn = (state_q == ST_PDN);
    wire busy = (state_q == ST_DLY) | (state_q == ST_CONV);

    // Reset pin: a low phase is only honoured if it lasted long enough.
    reg [2:0] rpl_cnt_q;
    wire pin_rst = rstp_rise & (rpl_cnt_q >= `ADCMS_RST_PIN_MIN_CLKS);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rpl_cnt_q <= 3'h0;
        end else if (ce_i) begin
            if (pf_q[`ADCMS_PIN_RST]) begin
                rpl_cnt_q <= 3'h0;
            end else if (rpl_cnt_q < `ADCMS_RST_PIN_MIN_CLKS) begin
                rpl_cnt_q <= rpl_cnt_q + 3'h1;
            end
        end
    end

    // Serial command shifter, bits taken on falling serial clock.
    reg [2:0] bit_cnt_q;
    reg [6:0] sr_q;
    wire op_stb = cs_act & sclk_fall & (bit_cnt_q == 3'h6);
    wire [6:0] op = {sr_q[5:0], din};

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_q <= 3'h0;
            sr_q <= 7'h00;
        end else if (ce_i) begin
            if (!cs_act) begin
                bit_cnt_q <= 3'h0;
            end else if (sclk_fall) begin
                sr_q <= {sr_q[5:0], din};
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
        end
    end

    wire op_rst = op_stb & (op == `ADCMS_OP_RESET) & ~in_pdn;
    wire op_sleep = op_stb & (op == `ADCMS_OP_SLEEP) & ~in_pdn;
    wire op_resume = op_stb & (op == `ADCMS_OP_RESUME) & in_pdn;
    wire op_start = op_stb & (op == `ADCMS_OP_START);
    wire op_stop = op_stb & (op == `ADCMS_OP_STOP);
    wire op_cal = op_stb & (op == `ADCMS_OP_CAL) & busy;
    wire srst = op_rst | pin_rst;

    // Configuration registers.
    reg [15:0] gain_q;
    reg [1:0] drate_q;
    reg [2:0] ref_q;
    reg [7:0] exc1_q;
    reg [7:0] exc2_q;
    reg clk_q;
    wire mode_single = drate_q[`ADCMS_DRATE_MODE];
    wire low_lat = drate_q[`ADCMS_DRATE_LOWLAT];

    // Start, stop and sleep all pass the same fixed latency.
    reg [3*LAT-1:0] cp_q;
    wire [2:0] cp_in;
    wire sleep_eff = cp_q[3*LAT-1];
    wire start_eff = cp_q[3*LAT-2];
    wire stop_eff = cp_q[3*LAT-3];

    assign cp_in = {op_sleep, op_start | trig_rise, op_stop | (trig_fall & ~mode_single)};

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cp_q <= {3*LAT{1'b0}};
        end else if (ce_i) begin
            if (srst) begin
                cp_q <= {3*LAT{1'b0}};
            end else begin
                cp_q <= {cp_q[3*LAT-4:0], cp_in};
            end
        end
    end

    // Wishbone slave: ack one cycle after the request, write lands with ack.
    wire [7:0] idx = wb_adr_i[9:2];
    wire wb_req = wb_cyc_i & wb_stb_i;
    wire wb_wr = wb_req & wb_we_i & wb_ack_o;
    wire cfg_wr_ok = wb_wr & ~in_pdn;
    wire cfg_touch = cfg_wr_ok & (idx >= `ADCMS_IDX_GAIN) & (idx <= `ADCMS_IDX_EXC2);
    wire [15:0] wm16 = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [7:0] wm8 = {8{wb_sel_i[0]}};
    reg [31:0] rd_data;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gain_q <= `ADCMS_GAIN_RST;
            drate_q <= `ADCMS_DRATE_RST;
            ref_q <= `ADCMS_REF_RST;
            exc1_q <= `ADCMS_EXC_RST;
            exc2_q <= `ADCMS_EXC_RST;
            clk_q <= `ADCMS_CLK_RST;
        end else if (ce_i) begin
            if (srst) begin
                gain_q <= `ADCMS_GAIN_RST;
                drate_q <= `ADCMS_DRATE_RST;
                ref_q <= `ADCMS_REF_RST;
                exc1_q <= `ADCMS_EXC_RST;
                exc2_q <= `ADCMS_EXC_RST;
                clk_q <= `ADCMS_CLK_RST;
            end else if (cfg_wr_ok) begin
                case (idx)
                    `ADCMS_IDX_GAIN: begin
                        gain_q <= (gain_q & ~wm16) | (wb_dat_i[15:0] & wm16);
                    end
                    `ADCMS_IDX_DRATE: begin
                        drate_q <= (drate_q & ~wm8[1:0]) | (wb_dat_i[1:0] & wm8[1:0]);
                    end
                    `ADCMS_IDX_REF: begin
                        ref_q <= (ref_q & ~wm8[2:0]) | (wb_dat_i[2:0] & wm8[2:0]);
                    end
                    `ADCMS_IDX_EXC1: begin
                        exc1_q <= (exc1_q & ~wm8) | (wb_dat_i[7:0] & wm8);
                    end
                    `ADCMS_IDX_EXC2: begin
                        exc2_q <= (exc2_q & ~wm8) | (wb_dat_i[7:0] & wm8);
                    end
                    `ADCMS_IDX_CLKSEL: begin
                        if (wb_sel_i[0]) begin
                            clk_q <= wb_dat_i[`ADCMS_CLK_EXT];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Start-up timer; the flag set wins over a same-cycle software clear.
    reg [16:0] por_cnt_q;
    reg ready_q;
    reg supply_up_q;
    wire por_done = ~ready_q & (por_cnt_q == STARTUP_CLKS - 17'h1);
    wire sup_clr = wb_wr & (idx == `ADCMS_IDX_STATUS) & wb_sel_i[0] & wb_dat_i[`ADCMS_STAT_SUPUP];

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_q <= 17'h00000;
            ready_q <= 1'b0;
            supply_up_q <= 1'b0;
        end else if (ce_i) begin
            if (!ready_q) begin
                por_cnt_q <= por_cnt_q + 17'h00001;
            end
            if (por_done) begin
                ready_q <= 1'b1;
                supply_up_q <= 1'b1;
            end else if (sup_clr) begin
                supply_up_q <= 1'b0;
            end
        end
    end

    always @* begin
        rd_data = 32'h00000000;
        case (idx)
            `ADCMS_IDX_STATUS: begin
                rd_data[`ADCMS_STAT_RDYN] = ~ready_q;
                rd_data[`ADCMS_STAT_SUPUP] = supply_up_q;
                rd_data[`ADCMS_STAT_ST_LO+3:`ADCMS_STAT_ST_LO] = state_q;
            end
            `ADCMS_IDX_GAIN: rd_data[15:0] = gain_q;
            `ADCMS_IDX_DRATE: rd_data[1:0] = drate_q;
            `ADCMS_IDX_REF: rd_data[2:0] = ref_q;
            `ADCMS_IDX_EXC1: rd_data[7:0] = exc1_q;
            `ADCMS_IDX_EXC2: rd_data[7:0] = exc2_q;
            `ADCMS_IDX_CLKSEL: rd_data[`ADCMS_CLK_EXT] = clk_q;
            default: begin
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    // Settle counter load in clocks: (field + 1) modulator periods, minus one.
    wire [12:0] n_mod = {1'b0, gain_q[`ADCMS_GAIN_DLY_HI:`ADCMS_GAIN_DLY_LO]} + 13'h0001;
    wire [16:0] dly_ld = ({4'h0, n_mod} << `ADCMS_TMOD_SHIFT) - 17'h00001;
    wire [15:0] conv_ld = `ADCMS_CONV_CLKS - 16'h0001;

    reg [16:0] dly_cnt_q;
    reg [15:0] conv_cnt_q;
    reg [1:0] shot_q;
    reg stop_pend_q;
    reg drdy_n_q;
    reg [3:0] state_d;
    reg [16:0] dly_d;
    reg [15:0] conv_d;
    reg [1:0] shot_d;
    reg pend_d;
    reg drdy_d;
    reg valid_d;

    always @* begin
        state_d = state_q;
        dly_d = dly_cnt_q;
        conv_d = conv_cnt_q;
        shot_d = shot_q;
        pend_d = stop_pend_q;
        drdy_d = drdy_n_q;
        valid_d = 1'b0;
        if (sclk_rise & cs_act) begin
            drdy_d = 1'b1;
        end
        if (stop_eff & busy) begin
            pend_d = 1'b1;
        end
        case (state_q)
            ST_PDN: begin
                if (op_resume) begin
                    state_d = ST_STBY;
                end
            end
            ST_STBY: begin
                if (start_eff) begin
                    state_d = ST_DLY;
                    dly_d = dly_ld;
                    shot_d = 2'h0;
                    pend_d = 1'b0;
                    drdy_d = 1'b1;
                end
            end
            ST_DLY: begin
                if (start_eff | cfg_touch) begin
                    dly_d = dly_ld;
                    shot_d = 2'h0;
                    if (start_eff) begin
                        pend_d = 1'b0;
                    end
                end else if (dly_cnt_q == 17'h00000) begin
                    state_d = ST_CONV;
                    conv_d = conv_ld;
                end else begin
                    dly_d = dly_cnt_q - 17'h00001;
                end
            end
            ST_CONV: begin
                if (start_eff | cfg_touch) begin
                    // A new start abandons the running conversion.
                    state_d = ST_DLY;
                    dly_d = dly_ld;
                    shot_d = 2'h0;
                    if (start_eff) begin
                        pend_d = 1'b0;
                    end
                end else if (conv_cnt_q != 16'h0000) begin
                    conv_d = conv_cnt_q - 16'h0001;
                end else if (mode_single & ~low_lat & (shot_q != `ADCMS_SINC3_SKIP)) begin
                    shot_d = shot_q + 2'h1;
                    conv_d = conv_ld;
                end else begin
                    valid_d = 1'b1;
                    drdy_d = 1'b0;
                    shot_d = 2'h0;
                    if (mode_single | pend_d) begin
                        state_d = ST_STBY;
                        pend_d = 1'b0;
                    end else begin
                        conv_d = conv_ld;
                    end
                end
            end
            default: begin
                state_d = ST_STBY;
            end
        endcase
        if (sleep_eff) begin
            state_d = ST_PDN;
            pend_d = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_STBY;
            dly_cnt_q <= 17'h00000;
            conv_cnt_q <= 16'h0000;
            shot_q <= 2'h0;
            stop_pend_q <= 1'b0;
            drdy_n_q <= 1'b1;
            result_valid_o <= 1'b0;
            cal_start_o <= 1'b0;
        end else if (ce_i) begin
            if (srst) begin
                state_q <= ST_STBY;
                shot_q <= 2'h0;
                stop_pend_q <= 1'b0;
                drdy_n_q <= 1'b1;
                result_valid_o <= 1'b0;
            end else begin
                state_q <= state_d;
                dly_cnt_q <= dly_d;
                conv_cnt_q <= conv_d;
                shot_q <= shot_d;
                stop_pend_q <= pend_d;
                drdy_n_q <= drdy_d;
                result_valid_o <= valid_d;
            end
            cal_start_o <= op_cal & ~srst;
        end
    end

    // Power and clock steering follow the next state so they switch with it.
    wire pdn_d = srst ? 1'b0 : (state_d == ST_PDN);
    wire run_d = ~srst & ((state_d == ST_DLY) | (state_d == ST_CONV));
    wire amp_on = gain_q[`ADCMS_GAIN_AMP_HI:`ADCMS_GAIN_AMP_LO] != 2'h0;
    wire vref_on = ref_q[`ADCMS_REF_VREF_HI:`ADCMS_REF_VREF_LO] != 2'h0;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            filt_rst_o <= 1'b1;
            core_clk_en_o <= 1'b0;
            pwr_down_o <= 1'b0;
            amp_pwr_o <= 1'b0;
            vref_pwr_o <= 1'b0;
            idac_pwr_o <= 1'b0;
            clk_ext_sel_o <= 1'b0;
            drdy_n_o <= 1'b1;
            mode_state_o <= ST_STBY;
        end else if (ce_i) begin
            filt_rst_o <= ~run_d;
            core_clk_en_o <= run_d;
            pwr_down_o <= pdn_d;
            amp_pwr_o <= ~pdn_d & (run_d | amp_on);
            // The reference alone may be kept alive through power-down.
            vref_pwr_o <= pdn_d ? ref_q[`ADCMS_REF_KEEP] : (run_d | vref_on);
            idac_pwr_o <= ~pdn_d & (run_d | vref_on);
            clk_ext_sel_o <= srst ? `ADCMS_CLK_RST : clk_q;
            drdy_n_o <= srst ? 1'b1 : drdy_d;
            mode_state_o <= srst ? ST_STBY : state_d;
        end
    end

endmodule // adcms_top
`default_nettype wire

/* verification/adcms_checker.sv */
`default_nettype none
module adcms_checker (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic conv_trig_i,
    input wire logic rst_pin_n_i,
    input wire logic drdy_n_o,
    input wire logic result_valid_o,
    input wire logic cal_start_o,
    input wire logic filt_rst_o,
    input wire logic core_clk_en_o,
    input wire logic pwr_down_o,
    input wire logic amp_pwr_o,
    input wire logic idac_pwr_o,
    input wire logic clk_ext_sel_o,
    input wire logic [3:0] mode_state_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Power and clock outputs switch in the same cycle as mode_state_o; the checks require a second cycle in the state.
    sequence standby_s;
        mode_state_o == 4'h2 && $past(mode_state_o) == 4'h2;
    endsequence
    sequence asleep_s;
        mode_state_o == 4'h1 && $past(mode_state_o) == 4'h1;
    endsequence
    sequence trig_rise_s;
        $rose(conv_trig_i) && mode_state_o == 4'h2;
    endsequence
    // The pin must have been low for at least four cycles before a release counts as a reset.
    sequence soft_rst_s;
        $rose(rst_pin_n_i) && !$past(rst_pin_n_i, 4) && !mode_state_o[0];
    endsequence

    state_onehot_a: assert property ($onehot(mode_state_o))
        else $error("Mode state is not one-hot");
    standby_gate_a: assert property (standby_s |-> filt_rst_o && !core_clk_en_o)
        else $error("Standby does not hold filter and gate clock");
    sleep_power_a: assert property (asleep_s |-> pwr_down_o && !amp_pwr_o && !idac_pwr_o && !core_clk_en_o)
        else $error("Power-down left circuits running");
    result_drdy_a: assert property (result_valid_o |-> !drdy_n_o)
        else $error("Result without data-ready low");
    result_src_a: assert property (result_valid_o |-> $past(mode_state_o) == 4'h8)
        else $error("Result outside a conversion");
    cal_gate_a: assert property (cal_start_o |-> $past(mode_state_o[3] | mode_state_o[2]))
        else $error("Calibration accepted in standby");
    trig_start_a: assert property (trig_rise_s |-> ##[3:8] mode_state_o == 4'h4)
        else $error("Trigger rise did not start settling");
    pin_reset_a: assert property (soft_rst_s |-> ##[3:7] (mode_state_o == 4'h2 && !clk_ext_sel_o))
        else $error("Reset pin did not restore standby and clock");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus acknowledge not a one-cycle answer");
endmodule // adcms_checker
`default_nettype wire

/* verification/adcms_host_model.sv */
`default_nettype none
module adcms_host_model (
    input wire logic clk_i,
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_din_o,
    output logic conv_trig_o,
    output logic rst_pin_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Four system cycles make half of the 160 ns link clock period.
    localparam int HALF = 4;

    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_din_o = 1'b0;
        conv_trig_o = 1'b0;
        rst_pin_n_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Data changes on the rising edge and is taken by the device on the falling edge.
    task automatic send_byte(input logic [7:0] b);
        spi_cs_n_o <= 1'b0;
        wait_clk(HALF);
        for (int i = 7; i >= 0; i--) begin
            spi_sclk_o <= 1'b1;
            spi_din_o <= b[i];
            wait_clk(HALF);
            spi_sclk_o <= 1'b0;
            wait_clk(HALF);
        end
        spi_cs_n_o <= 1'b1;
        spi_din_o <= ~b[0];
        wait_clk(HALF);
    endtask

    task automatic set_trig(input logic v);
        conv_trig_o <= v;
        wait_clk(1);
    endtask

    task automatic pulse_rst(input int n);
        rst_pin_n_o <= 1'b0;
        wait_clk(n);
        rst_pin_n_o <= 1'b1;
        wait_clk(1);
    endtask
endmodule // adcms_host_model
`default_nettype wire

/* verification/adc_mode_sequencer_tb_top.sv */
`default_nettype none
module adc_mode_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] idx; logic [31:0] mask; logic [31:0] want;} adcms_row_t;
    logic clk_i, nrst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, spi_sclk_i, spi_cs_n_i, spi_din_i;
    logic conv_trig_i, rst_pin_n_i, drdy_n_o, result_valid_o, cal_start_o, filt_rst_o, core_clk_en_o;
    logic pwr_down_o, amp_pwr_o, vref_pwr_o, idac_pwr_o, clk_ext_sel_o, ce_i = 1'b1;
    logic [9:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i, mode_state_o;
    int fail_count = 0, samples_checked = 0, cyc_cnt = 0, st4_cnt = 0, st8_cnt = 0, cal_cnt = 0, a4, a8, c0;
    adcms_row_t rows[8] = '{'{8'h01, 32'hFF, 32'h22}, '{8'h03, 32'hFFFF, 32'hD1}, '{8'h04, 32'h3, 32'h0},
        '{8'h05, 32'h7, 32'h1}, '{8'h06, 32'hFF, 32'h0}, '{8'h07, 32'hFF, 32'h0}, '{8'h0C, 32'h1, 32'h0},
        '{8'h20, 32'hFFFFFFFF, 32'h0}};

    adcms_top #(.STARTUP_CLKS(17'd20)) dut_u (.clk_i, .nrst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .spi_sclk_i, .spi_cs_n_i, .spi_din_i,
        .conv_trig_i, .rst_pin_n_i, .drdy_n_o, .result_valid_o, .cal_start_o, .filt_rst_o, .core_clk_en_o,
        .pwr_down_o, .amp_pwr_o, .vref_pwr_o, .idac_pwr_o, .clk_ext_sel_o, .mode_state_o);
    adcms_host_model host_u (.clk_i, .spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i), .spi_din_o(spi_din_i),
        .conv_trig_o(conv_trig_i), .rst_pin_n_o(rst_pin_n_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        st4_cnt <= st4_cnt + (mode_state_o === 4'h4);
        st8_cnt <= st8_cnt + (mode_state_o === 4'h8);
        cal_cnt <= cal_cnt + (cal_start_o === 1'b1);
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] want, input logic [31:0] got);
        samples_checked++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, want, got);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_state(input logic [3:0] m, input int lim);
        int n;
        n = 0;
        while (mode_state_o !== m && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wait_pulse();
        int n;
        n = 0;
        while (result_valid_o !== 1'b1 && n < 5000) begin
            @(posedge clk_i);
            n++;
        end
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        nrst_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 10'h000;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h3;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wb(1'b0, 8'h01, 32'h0);
        chk("early status", 32'h1, rd & 32'h3);
        repeat (25) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            wb(1'b0, rows[i].idx, 32'h0);
            chk("reg read", rows[i].want, rd & rows[i].mask);
        end
        chk("idle after reset", 32'h2, mode_state_o);
        for (int i = 6; i < 8; i++) begin
            wb(1'b1, 8'h0C, 32'h1);
            wb(1'b1, 8'h03, 32'h0);
            wb(1'b1, 8'h05, 32'h0);
            repeat (2) @(posedge clk_i);
            chk("powers off", 32'h8, {28'h0, clk_ext_sel_o, amp_pwr_o, vref_pwr_o, idac_pwr_o});
            host_u.send_byte(i[7:0]);
            chk("cmd reset", 32'h7, {28'h0, clk_ext_sel_o, amp_pwr_o, vref_pwr_o, idac_pwr_o});
        end
        wb_sel_i <= 4'h1;
        wb(1'b1, 8'h03, 32'hFF01);
        a4 = st4_cnt;
        a8 = st8_cnt;
        c0 = cal_cnt;
        host_u.send_byte(8'h08);
        wait_state(4'h8, 200);
        host_u.send_byte(8'h18);
        host_u.send_byte(8'h0A);
        wait_pulse();
        chk("settle clocks", 32'h10, st4_cnt - a4);
        chk("conv clocks", 32'h400, st8_cnt - a8);
        chk("cal pulses", 32'h1, cal_cnt - c0);
        chk("idle outputs", 32'h14, {mode_state_o, filt_rst_o, core_clk_en_o, drdy_n_o});
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, 8'h04, {30'h0, i[0], 1'b1});
            a4 = st4_cnt;
            a8 = st8_cnt;
            if (i == 0)
                host_u.set_trig(1'b1);
            else
                host_u.send_byte(8'h09);
            wait_pulse();
            chk("shot clocks", (i == 0) ? 32'hC00 : 32'h400, st8_cnt - a8);
            chk("shot settle", 32'h10, st4_cnt - a4);
            chk("shot idle", 32'h2, mode_state_o);
            host_u.set_trig(1'b0);
        end
        host_u.send_byte(8'h04);
        chk("asleep", 32'h30, {mode_state_o, pwr_down_o, amp_pwr_o, vref_pwr_o, idac_pwr_o, core_clk_en_o});
        wb(1'b1, 8'h03, 32'hFF);
        wb(1'b0, 8'h03, 32'h0);
        chk("write ignored", 32'h1, rd & 32'hFFFF);
        host_u.send_byte(8'h06);
        chk("reset ignored", 32'h1, mode_state_o);
        ce_i <= 1'b0;
        host_u.send_byte(8'h02);
        ce_i <= 1'b1;
        chk("frozen", 32'h1, mode_state_o);
        host_u.send_byte(8'h02);
        chk("resumed", 32'h2, mode_state_o);
        c0 = cal_cnt;
        host_u.send_byte(8'h18);
        chk("cal in standby", 32'h0, cal_cnt - c0);
        wb(1'b1, 8'h0C, 32'h1);
        host_u.pulse_rst(6);
        repeat (6) @(posedge clk_i);
        chk("pin reset", 32'h2, {clk_ext_sel_o, mode_state_o});
        wb(1'b0, 8'h03, 32'h0);
        chk("gain default", 32'hD1, rd & 32'hFFFF);
        wrap_up();
    end
endmodule // adc_mode_sequencer_tb_top

bind adcms_top adcms_checker chk_u (.clk_i, .nrst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .conv_trig_i, .rst_pin_n_i,
    .drdy_n_o, .result_valid_o, .cal_start_o, .filt_rst_o, .core_clk_en_o, .pwr_down_o, .amp_pwr_o, .idac_pwr_o,
    .clk_ext_sel_o, .mode_state_o);
`default_nettype wire
